/* core/tap_chain_defs.svh */
// Purpose: constants of the three-port serial test chain
// Assumes: four-bit instruction registers in every port
// Notes: definitions only
`ifndef TAP_CHAIN_DEFS_SVH
`define TAP_CHAIN_DEFS_SVH
`define TAP_COUNT 3
`define CHAIN_BSCAN 0
`define CHAIN_DEBUG 1
`define CHAIN_FLASH 2
`define TAP_IR_W 4
`define TAP_DR_W 16
`define TAP_DR_MIN 4
`define IR_CAPTURE 4'h1
`define INSTR_BYPASS 4'hF
`define INSTR_DATA 4'h2
`define INSTR_SYSRST 4'h3
`define FLASH_OP_W 2
`define FLASH_OP_PROG 2'h1
`define FLASH_OP_ERASE 2'h2
`define FLASH_OP_BOOT 2'h3
`define BOOT_SEL_RESET 1'h0
`define CLOCK_RATIO_MIN 10
`define TGL_FILL 2'h3
`endif

/* core/tap_chain_pkg.sv */
// Purpose: types and the controller step function
// Assumes: standard sixteen-state encoding
// Notes: shared by every test access port
package tap_chain_pkg;
    typedef enum logic [3:0] {
        TLR = 4'b1111, RTI = 4'b1100, SEL_DR = 4'b0111, CAP_DR = 4'b0110,
        SH_DR = 4'b0010, EX1_DR = 4'b0001, PA_DR = 4'b0011, EX2_DR = 4'b0000,
        UPD_DR = 4'b0101, SEL_IR = 4'b0100, CAP_IR = 4'b1110, SH_IR = 4'b1010,
        EX1_IR = 4'b1001, PA_IR = 4'b1011, EX2_IR = 4'b1000, UPD_IR = 4'b1101
    } tap_state_type;

    function automatic tap_state_type tap_next(input tap_state_type s, input logic tms);
        tap_state_type n;
        n = TLR;
        case (s)
            TLR: n = tms ? TLR : RTI;
            RTI: n = tms ? SEL_DR : RTI;
            SEL_DR: n = tms ? SEL_IR : CAP_DR;
            CAP_DR: n = tms ? EX1_DR : SH_DR;
            SH_DR: n = tms ? EX1_DR : SH_DR;
            EX1_DR: n = tms ? UPD_DR : PA_DR;
            PA_DR: n = tms ? EX2_DR : PA_DR;
            EX2_DR: n = tms ? UPD_DR : SH_DR;
            UPD_DR: n = tms ? SEL_DR : RTI;
            SEL_IR: n = tms ? TLR : CAP_IR;
            CAP_IR: n = tms ? EX1_IR : SH_IR;
            SH_IR: n = tms ? EX1_IR : SH_IR;
            EX1_IR: n = tms ? UPD_IR : PA_IR;
            PA_IR: n = tms ? EX2_IR : PA_IR;
            EX2_IR: n = tms ? UPD_IR : SH_IR;
            UPD_IR: n = tms ? SEL_DR : RTI;
            default: n = TLR;
        endcase
        return n;
    endfunction : tap_next
endpackage : tap_chain_pkg

/* core/tap_link_if.sv */
// Purpose: link between the chain top and one test access port
// Assumes: all signals live in the test clock domain
// Notes: core side feeds serial input and capture word
`timescale 1ns/10ps
`include "tap_chain_defs.svh"
interface tap_link_if #(parameter int DR_W = `TAP_DR_W);
    logic scan_in;
    logic scan_out;
    logic shifting;
    logic update_dr;
    logic [`TAP_IR_W-1:0] instr;
    logic [DR_W-1:0] capture_val;
    logic [DR_W-1:0] dr_value;
    modport unit (input scan_in, capture_val,
        output scan_out, shifting, update_dr, instr, dr_value);
    modport core (output scan_in, capture_val,
        input scan_out, shifting, update_dr, instr, dr_value);
endinterface : tap_link_if

/* core/tap_unit.sv */
// Purpose: one test access port with controller, instruction and data paths
// Assumes: mode select and serial input settle before the rising test clock
// Notes: unknown instructions fall back to the one-bit bypass path
`timescale 1ns/10ps
`include "tap_chain_defs.svh"
module tap_unit #(
    parameter int DR_W = `TAP_DR_W
) (
    // test clock domain
    input wire logic tck,
    input wire logic tap_rst,
    input wire logic tms,
    // chain link
    tap_link_if.unit lnk
);
    tap_chain_pkg::tap_state_type state_r;
    tap_chain_pkg::tap_state_type state_nxt;
    logic [`TAP_IR_W-1:0] ir_shift_r;
    logic [`TAP_IR_W-1:0] instr_r;
    logic bypass_r;
    logic [DR_W-1:0] dr_r;
    wire data_sel;
    wire in_sh_ir;
    wire in_sh_dr;

    if (DR_W < `TAP_DR_MIN) begin : g_bad_width
        $error("tap_unit: data register too narrow");
    end

    assign state_nxt = tap_chain_pkg::tap_next(state_r, tms); // [RQ15]
    assign data_sel = (instr_r == `INSTR_DATA);
    assign in_sh_ir = (state_r == tap_chain_pkg::SH_IR);
    assign in_sh_dr = (state_r == tap_chain_pkg::SH_DR);

    always_ff @(posedge tck or posedge tap_rst) begin
        if (tap_rst) begin
            state_r <= tap_chain_pkg::TLR; // [RQ10]
        end else begin
            state_r <= state_nxt; // [RQ15]
        end
    end

    always_ff @(posedge tck or posedge tap_rst) begin
        if (tap_rst) begin
            ir_shift_r <= `IR_CAPTURE;
            instr_r <= `INSTR_BYPASS; // [RQ7]
        end else begin
            case (state_r)
                tap_chain_pkg::TLR: instr_r <= `INSTR_BYPASS; // [RQ11]
                tap_chain_pkg::CAP_IR: ir_shift_r <= `IR_CAPTURE; // [RQ5]
                tap_chain_pkg::SH_IR: ir_shift_r <= {lnk.scan_in, ir_shift_r[`TAP_IR_W-1:1]};
                tap_chain_pkg::UPD_IR: instr_r <= ir_shift_r;
                default: instr_r <= instr_r;
            endcase
        end
    end

    always_ff @(posedge tck or posedge tap_rst) begin
        if (tap_rst) begin
            bypass_r <= 1'h0;
            dr_r <= '0;
        end else if (state_r == tap_chain_pkg::CAP_DR) begin
            bypass_r <= 1'h0; // [RQ16]
            dr_r <= data_sel ? lnk.capture_val : dr_r;
        end else if (in_sh_dr) begin
            bypass_r <= lnk.scan_in; // [RQ16]
            dr_r <= data_sel ? {lnk.scan_in, dr_r[DR_W-1:1]} : dr_r;
        end
    end

    assign lnk.scan_out = in_sh_ir ? ir_shift_r[0] : (data_sel ? dr_r[0] : bypass_r);
    assign lnk.shifting = in_sh_ir || in_sh_dr;
    assign lnk.update_dr = (state_r == tap_chain_pkg::UPD_DR);
    assign lnk.instr = instr_r;
    assign lnk.dr_value = dr_r;

    a_tms_reset: assert property (@(posedge tck) disable iff (tap_rst) // [RQ11]
        tms [*5] |=> state_r == tap_chain_pkg::TLR)
        else $error("five high mode selects did not reach reset");
    a_ir_capture: assert property (@(posedge tck) disable iff (tap_rst) // [RQ5]
        state_r == tap_chain_pkg::CAP_IR |=> ir_shift_r == `IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    a_bypass_bit: assert property (@(posedge tck) disable iff (tap_rst) // [RQ16]
        in_sh_dr && !data_sel |=> ##0 lnk.scan_out == $past(lnk.scan_in) || in_sh_ir)
        else $error("bypass path is not one bit long");
    a_shift_hold: assert property (@(posedge tck) disable iff (tap_rst) // [RQ15]
        in_sh_dr && !tms |=> in_sh_dr)
        else $error("shift state left with mode select low");
    a_reset_bypass: assert property (@(posedge tck) disable iff (tap_rst) // [RQ10]
        state_r == tap_chain_pkg::TLR |=> instr_r == `INSTR_BYPASS)
        else $error("reset did not restore bypass");
endmodule : tap_unit

/* core/jtag_tap_chain.sv */
// Purpose: three-port serial test chain with adaptive return clock
// Assumes: test clock slower than the core clock, as the return clock enforces
// Notes: the test clock stops outside frames; core hand-offs are made safe
//
// Overview of operation
// RQ1: the tester waits for a rising return clock before its next rising test clock.
// RQ2: without return clock pacing the test clock stays ten times below the core clock.
// RQ3: the return clock follows the test clock only as fast as the core can see it.
// RQ4: the tester may ignore the return clock only with a guaranteed tenfold clock ratio.
// RQ5: the five serial port signals behave as a standard boundary scan port.
// RQ6: the boundary port is first, the debug port second and the flash port last.
// RQ7: only one port converses at a time while the other two sit in bypass.
// RQ8: the flash port carries program and erase commands for the flash memories.
// RQ9: a global reset from power-on or low voltage resets all three ports together.
// RQ10: a low test reset pin resets all three ports together.
// RQ11: a serial reset sequence resets all three ports together without the pin.
// RQ12: watchdog and system reset pin leave every port undisturbed.
// RQ13: the debug port can request a full system reset over the serial channel.
// RQ14: the boot flash selection bit is written only through the serial test port.
// RQ15: each port runs the standard sixteen-state controller on the rising test clock.
// RQ16: an idle port offers a one-bit bypass register between its input and output.
`timescale 1ns/10ps
`include "tap_chain_defs.svh"
module jtag_tap_chain #(
    parameter int DR_W = `TAP_DR_W
) (
    // core clock domain
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // global reset sources
    input wire logic power_on_reset,
    input wire logic low_voltage_detect,
    // serial test port
    input wire logic test_clock_in,
    input wire logic test_reset_n,
    input wire logic test_mode_select,
    input wire logic test_data_in,
    output logic test_data_out,
    output logic test_data_out_en,
    output logic return_test_clock,
    // boundary sample pins
    input wire logic [DR_W-1:0] pin_sample,
    // flash side
    input wire logic flash_busy,
    output logic flash_cmd_valid,
    output logic [`FLASH_OP_W-1:0] flash_cmd_op,
    output logic [DR_W-`FLASH_OP_W-1:0] flash_cmd_arg,
    output logic boot_select,
    // system side
    output logic system_reset_req
);
    if (DR_W < `TAP_DR_MIN) begin : g_bad_width
        $error("jtag_tap_chain: data register too narrow");
    end

    // test clock domain
    wire tap_rst;
    wire flash_load;
    logic flash_tgl_r;
    logic [DR_W-1:0] flash_word_r;
    logic sysrst_lvl_r;
    logic busy_t1_r;
    logic busy_t2_r;
    logic boot_t1_r;
    logic boot_t2_r;
    logic [DR_W-1:0] pin_s1_r;
    logic [DR_W-1:0] pin_s2_r;
    logic tdo_r;
    logic tdo_en_r;

    // core clock domain
    logic tck_s1_r;
    logic tck_s2_r;
    logic rtck_r;
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic sreq_s1_r;
    logic sreq_s2_r;
    logic sysreq_r;
    logic cmd_valid_r;
    logic [`FLASH_OP_W-1:0] cmd_op_r;
    logic [DR_W-`FLASH_OP_W-1:0] cmd_arg_r;
    logic boot_sel_r;
    wire cmd_seen;
    logic [1:0] fill_r;
    wire chain_full;
    wire [`FLASH_OP_W-1:0] word_op;
    wire cmd_fire;
    wire boot_write;

    // only the global sources and the pin reach the ports; the system
    // reset and the watchdog are deliberately not wired in here
    assign tap_rst = power_on_reset || low_voltage_detect || !test_reset_n; // [RQ9] [RQ10] [RQ12]

    tap_link_if #(.DR_W(DR_W)) link [`TAP_COUNT] ();

    for (genvar g = 0; g < `TAP_COUNT; g++) begin : g_tap
        tap_unit #(.DR_W(DR_W)) u_tap (
            .tck(test_clock_in),
            .tap_rst(tap_rst),
            .tms(test_mode_select),
            .lnk(link[g])
        );
        if (g == 0) begin : g_head
            assign link[g].scan_in = test_data_in; // [RQ6]
        end else begin : g_next
            assign link[g].scan_in = link[g-1].scan_out; // [RQ6]
        end
    end

    assign link[`CHAIN_BSCAN].capture_val = pin_s2_r;
    assign link[`CHAIN_DEBUG].capture_val = {{(DR_W-1){1'h0}}, sysrst_lvl_r};
    assign link[`CHAIN_FLASH].capture_val = {busy_t2_r, boot_t2_r, {(DR_W-2){1'h0}}};

    assign flash_load = link[`CHAIN_FLASH].update_dr
        && (link[`CHAIN_FLASH].instr == `INSTR_DATA); // [RQ8]

    // the word is held until the next update, many test clocks later,
    // so the core may read it once the toggle has crossed
    always_ff @(posedge test_clock_in or posedge tap_rst) begin
        if (tap_rst) begin
            flash_tgl_r <= 1'h0;
            flash_word_r <= '0;
        end else if (flash_load) begin
            flash_tgl_r <= !flash_tgl_r; // [RQ8]
            flash_word_r <= link[`CHAIN_FLASH].dr_value; // [RQ2]
        end
    end

    always_ff @(posedge test_clock_in or posedge tap_rst) begin
        if (tap_rst) begin
            sysrst_lvl_r <= 1'h0;
        end else begin
            sysrst_lvl_r <= (link[`CHAIN_DEBUG].instr == `INSTR_SYSRST); // [RQ13]
        end
    end

    always_ff @(posedge test_clock_in or posedge tap_rst) begin
        if (tap_rst) begin
            busy_t1_r <= 1'h0;
            busy_t2_r <= 1'h0;
            boot_t1_r <= 1'h0;
            boot_t2_r <= 1'h0;
        end else begin
            busy_t1_r <= flash_busy;
            busy_t2_r <= busy_t1_r;
            boot_t1_r <= boot_sel_r;
            boot_t2_r <= boot_t1_r;
        end
    end

    // pins are sampled bit by bit with no word coherence, as a boundary sample allows
    always_ff @(posedge test_clock_in or posedge tap_rst) begin
        if (tap_rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= pin_sample;
            pin_s2_r <= pin_s1_r;
        end
    end

    // serial output changes on the falling edge, as the port standard expects
    always_ff @(negedge test_clock_in or posedge tap_rst) begin
        if (tap_rst) begin
            tdo_r <= 1'h0;
            tdo_en_r <= 1'h0;
        end else begin
            tdo_r <= link[`CHAIN_FLASH].scan_out; // [RQ5] [RQ6]
            tdo_en_r <= link[`CHAIN_BSCAN].shifting; // [RQ5]
        end
    end

    assign test_data_out = tdo_r;
    assign test_data_out_en = tdo_en_r;

    // return clock: the test clock as the core has seen it; a frozen core
    // also freezes the pacing, which holds the tester off
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tck_s1_r <= 1'h0;
            tck_s2_r <= 1'h0;
            rtck_r <= 1'h0;
        end else if (clk_en) begin
            tck_s1_r <= test_clock_in;
            tck_s2_r <= tck_s1_r;
            rtck_r <= tck_s2_r; // [RQ3] [RQ1]
        end
    end

    assign return_test_clock = rtck_r;

    // after a core reset the toggle chain refills from a flag that reset left alone;
    // a difference seen before it is full would replay the last command
    assign chain_full = (fill_r == `TGL_FILL);
    assign cmd_seen = chain_full && (tgl_s2_r ^ tgl_s3_r);
    assign word_op = flash_word_r[DR_W-1:DR_W-`FLASH_OP_W];
    assign cmd_fire = cmd_seen
        && (word_op == `FLASH_OP_PROG || word_op == `FLASH_OP_ERASE); // [RQ8]
    assign boot_write = cmd_seen && (word_op == `FLASH_OP_BOOT); // [RQ14]

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_s1_r <= 1'h0;
            tgl_s2_r <= 1'h0;
            tgl_s3_r <= 1'h0;
        end else if (clk_en) begin
            tgl_s1_r <= flash_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    // the request is a level, so a core reset only hides it until it resyncs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sreq_s1_r <= 1'h0;
            sreq_s2_r <= 1'h0;
            sysreq_r <= 1'h0;
        end else if (clk_en) begin
            sreq_s1_r <= sysrst_lvl_r;
            sreq_s2_r <= sreq_s1_r;
            sysreq_r <= sreq_s2_r; // [RQ13]
        end
    end

    // a toggle arriving while the chain refills is lost; commands are far apart
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fill_r <= '0;
        end else if (clk_en && !chain_full) begin
            fill_r <= fill_r + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_valid_r <= 1'h0;
            cmd_op_r <= '0;
            cmd_arg_r <= '0;
        end else if (clk_en) begin
            cmd_valid_r <= cmd_fire; // [RQ8]
            if (cmd_fire) begin
                cmd_op_r <= word_op;
                cmd_arg_r <= flash_word_r[DR_W-`FLASH_OP_W-1:0];
            end
        end
    end

    // no core write path exists for the boot selection
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_sel_r <= `BOOT_SEL_RESET;
        end else if (clk_en && boot_write) begin
            boot_sel_r <= flash_word_r[0]; // [RQ14]
        end
    end

    assign flash_cmd_valid = cmd_valid_r;
    assign flash_cmd_op = cmd_op_r;
    assign flash_cmd_arg = cmd_arg_r;
    assign boot_select = boot_sel_r;
    assign system_reset_req = sysreq_r;

    a_rtck_follow: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ3]
        (clk_en && tck_s1_r) [*3] |=> return_test_clock)
        else $error("return clock did not follow a steady test clock");
    a_rtck_freeze: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ3]
        !clk_en |=> $stable(return_test_clock))
        else $error("return clock moved while the core was frozen");
    a_chain_order: assert property (@(posedge test_clock_in) disable iff (tap_rst) // [RQ6]
        link[1].scan_in == link[0].scan_out && link[2].scan_in == link[1].scan_out)
        else $error("port chain order broken");
    a_sysrst_req: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ13]
        clk_en && $rose(sreq_s2_r) |=> system_reset_req)
        else $error("system reset request not forwarded");
    a_boot_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ14]
        $changed(boot_select) |-> $past(boot_write) && $past(clk_en))
        else $error("boot selection changed without a serial command");
    a_flash_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ8]
        flash_cmd_valid && clk_en |=> !flash_cmd_valid)
        else $error("flash command strobe longer than one cycle");
    a_cmd_load: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ8]
        cmd_fire && clk_en |=> flash_cmd_valid && flash_cmd_op == $past(word_op))
        else $error("flash command not presented with its operation");
    a_flash_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ8]
        !cmd_fire |=> $stable(flash_cmd_op) && $stable(flash_cmd_arg))
        else $error("flash command fields moved without a command");
    a_fill_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ8]
        !chain_full |=> !flash_cmd_valid)
        else $error("flash command issued while the toggle chain refills");
    a_sysreq_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ13]
        clk_en && !sreq_s2_r |=> !system_reset_req)
        else $error("system reset request held without its source");
    a_rtck_fall: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ3]
        (clk_en && !tck_s2_r) [*2] |=> !return_test_clock)
        else $error("return clock did not fall after a low test clock");
    a_tdo_enable: assert property (@(posedge test_clock_in) disable iff (tap_rst) // [RQ5]
        test_data_out_en == link[`CHAIN_BSCAN].shifting)
        else $error("data out enable does not follow the shift states");
    a_tdo_value: assert property (@(posedge test_clock_in) disable iff (tap_rst) // [RQ5]
        test_data_out == link[`CHAIN_FLASH].scan_out)
        else $error("data out does not carry the last port output");
endmodule : jtag_tap_chain

/* test/jtag_tester.sv */
// Purpose: far-side test equipment model driving the serial test port
// Assumes: one serial step at a time, called from the bench
// Notes: the test clock only runs inside steps and idles low between them
`timescale 1ns/10ps
module jtag_tester (
    // lines driven toward the device
    output logic test_clock_in,
    output logic test_mode_select,
    output logic test_data_in,
    // lines returned by the device
    input wire logic test_data_out,
    input wire logic return_test_clock
);
    int rise_wait;

    initial begin
        test_clock_in = 1'b0;
        test_mode_select = 1'b1;
        test_data_in = 1'b0;
        rise_wait = 0;
    end

    // one test clock period; mode select and data held until the clock falls
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        int k;
        test_mode_select = tms;
        test_data_in = tdi;
        #62.5;
        tdo = test_data_out;
        test_clock_in = 1'b1;
        k = 0;
        // never assume a clock ratio: always pace on the return clock
        while (return_test_clock !== 1'b1 && k < 4000) begin
            #1;
            k++;
        end
        rise_wait = k;
        #62.5;
        test_clock_in = 1'b0;
        k = 0;
        while (return_test_clock !== 1'b0 && k < 4000) begin
            #1;
            k++;
        end
        // data in is meaningless now, so show the inverse rather than a stale level
        test_data_in = ~tdi;
    endtask : step
endmodule : jtag_tester

/* test/jtag_tap_chain_test.sv */
// Purpose: self-checking bench of the three-port serial test chain
// Assumes: default data register width, tester paced by the return clock
// Notes: flash commands are noted in a queue and compared when they appear
`timescale 1ns/10ps
`include "tap_chain_defs.svh"
module jtag_tap_chain_test;
    localparam int W = `TAP_DR_W;
    localparam logic [1:0] OPS [5] = '{`FLASH_OP_BOOT, `FLASH_OP_PROG, `FLASH_OP_ERASE, 2'h0,
        `FLASH_OP_BOOT};
    logic ref_clk, sys_rst, clk_en, power_on_reset, low_voltage_detect, test_reset_n;
    logic tck, tms, tdi, tdo, tdo_en, rtck, b, boot_m;
    logic [W-1:0] pin_sample;
    logic flash_busy, flash_cmd_valid, boot_select, system_reset_req;
    logic [1:0] flash_cmd_op;
    logic [W-3:0] flash_cmd_arg;
    logic [31:0] notes[$];
    logic [31:0] got, w;
    int mismatches, n_checks, seed;

    jtag_tap_chain i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .power_on_reset(power_on_reset), .low_voltage_detect(low_voltage_detect),
        .test_clock_in(tck), .test_reset_n(test_reset_n), .test_mode_select(tms),
        .test_data_in(tdi), .test_data_out(tdo), .test_data_out_en(tdo_en),
        .return_test_clock(rtck), .pin_sample(pin_sample), .flash_busy(flash_busy),
        .flash_cmd_valid(flash_cmd_valid), .flash_cmd_op(flash_cmd_op),
        .flash_cmd_arg(flash_cmd_arg), .boot_select(boot_select),
        .system_reset_req(system_reset_req)
    );

    jtag_tester i_tester (
        .test_clock_in(tck), .test_mode_select(tms), .test_data_in(tdi),
        .test_data_out(tdo), .return_test_clock(rtck)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    function automatic logic rbit();
        logic [31:0] r;
        r = $random(seed);
        return r[0];
    endfunction : rbit

    // from idle or reset: scan n bits, LSB first, and come back to idle
    task automatic shift(input logic ir, input int n, input logic [31:0] w_in,
            output logic [31:0] w_out);
        logic q;
        w_out = '0;
        i_tester.step(1'b0, rbit(), q);
        i_tester.step(1'b1, rbit(), q);
        if (ir)
            i_tester.step(1'b1, rbit(), q);
        i_tester.step(1'b0, rbit(), q);
        i_tester.step(1'b0, rbit(), q);
        for (int i = 0; i < n; i++) begin
            i_tester.step(i == n - 1, w_in[i], q);
            w_out[i] = q;
            check(tdo_en, i != n - 1);
        end
        i_tester.step(1'b1, rbit(), q);
        i_tester.step(1'b0, rbit(), q);
    endtask : shift

    // results are checked at the falling core edge, clear of the launching edge
    always @(negedge ref_clk) begin
        if (flash_cmd_valid === 1'b1) begin
            if (notes.size() == 0)
                check(32'({flash_cmd_op, flash_cmd_arg}), 32'hFFFFFFFF);
            else
                check(32'({flash_cmd_op, flash_cmd_arg}), notes.pop_front());
        end
    end

    initial begin
        #500000;
        mismatches++;
        end_of_test();
    end

    initial begin
        seed = 38;
        mismatches = 0;
        n_checks = 0;
        boot_m = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        power_on_reset = 1'b1;
        low_voltage_detect = 1'b0;
        test_reset_n = 1'b0;
        pin_sample = '0;
        flash_busy = 1'b0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        power_on_reset <= 1'b0;
        test_reset_n <= 1'b1;
        @(posedge ref_clk);
        check(boot_select, `BOOT_SEL_RESET);
        shift(1'b1, 12, 32'hFFF, got);
        check(got, 32'h111);
        w = $random(seed);
        shift(1'b0, 16, w, got);
        check(got[15:0], {w[12:0], 3'b000});
        check(i_tester.rise_wait <= 40, 1'b1);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        // a frozen core must hold the tester off until it runs again
        fork
            i_tester.step(1'b0, 1'b0, b);
            begin
                repeat (60) @(posedge ref_clk);
                clk_en <= 1'b1;
            end
        join
        check(i_tester.rise_wait >= 350, 1'b1);
        for (int k = 0; k < 5; k++) begin
            @(posedge ref_clk);
            flash_busy <= rbit();
            w = $random(seed);
            w[W-1:W-2] = OPS[k];
            if (OPS[k] == `FLASH_OP_BOOT)
                w[0] = (k == 0);
            repeat (4) @(posedge ref_clk);
            shift(1'b1, 12, 32'hFF2, got);
            if (OPS[k] == `FLASH_OP_PROG || OPS[k] == `FLASH_OP_ERASE)
                notes.push_back(32'(w[W-1:0]));
            shift(1'b0, W + 2, w, got);
            check(got[W+1:0], {2'b00, flash_busy, boot_m, {(W-2){1'b0}}});
            if (OPS[k] == `FLASH_OP_BOOT)
                boot_m = w[0];
            repeat (10) @(posedge ref_clk);
            check(boot_select, boot_m);
        end
        @(posedge ref_clk);
        pin_sample <= W'($random(seed));
        repeat (4) @(posedge ref_clk);
        shift(1'b1, 12, 32'h2FF, got);
        shift(1'b0, W + 2, $random(seed), got);
        check(got[W+1:0], {pin_sample, 2'b00});
        // reset sources: core reset, power-on, low voltage, pin, serial sequence
        for (int s = 0; s < 5; s++) begin
            shift(1'b1, 12, 32'hF3F, got);
            // the request level is latched one test clock after the update
            i_tester.step(1'b0, rbit(), b);
            repeat (10) @(posedge ref_clk);
            check(system_reset_req, 1'b1);
            @(posedge ref_clk);
            case (s)
                0: sys_rst <= 1'b1;
                1: power_on_reset <= 1'b1;
                2: low_voltage_detect <= 1'b1;
                3: test_reset_n <= 1'b0;
                default: repeat (5) i_tester.step(1'b1, rbit(), b);
            endcase
            repeat (3) @(posedge ref_clk);
            sys_rst <= 1'b0;
            power_on_reset <= 1'b0;
            low_voltage_detect <= 1'b0;
            test_reset_n <= 1'b1;
            repeat (10) @(posedge ref_clk);
            check(system_reset_req, s == 0);
        end
        check(notes.size(), 0);
        end_of_test();
    end
endmodule : jtag_tap_chain_test
